// ---- rtl/tdc_decoder.sv ----
// Command decoder for a five-counter timing controller
`timescale 1ns/100ps
module tdc_decoder
   import tdc_pkg::*;
#(
   parameter int N = NUM_CNT
)(
   input  wire logic              clock,            // 250 MHz system clock
   input  wire logic              reset,            // Synchronous reset
   input  wire logic              cmd_valid,        // Command byte strobe
   input  wire logic [7:0]        cmd_byte,         // Command byte
   input  wire logic [N-1:0]      terminal_count,   // Counters at terminal count
   input  wire logic [N-1:0]      source_edge,      // Count source edge per counter
   input  wire logic [N-1:0]      tc_disarm,        // Datapath disarm on terminal count
   input  wire logic [N-1:0]      tc_toggle,        // Terminal count toggles the flop
   input  wire logic [N-1:0]      count_up_select,  // Count direction per counter
   input  wire logic [3*N-1:0]    output_control_field, // Output mode per counter
   input  wire logic              mm_write,         // Full master mode word write
   input  wire logic [MM_W-1:0]   mm_write_data,    // Master mode word
   input  wire logic              host_access,      // Host data access pulse
   input  wire logic [WORD_W-1:0] internal_word,    // Word at pointer location
   input  wire logic              freq_divided,     // Selected, divided frequency
   output logic [N-1:0]           counter_armed,    // Counting enabled
   output logic [N-1:0]           load_pulse,       // Load selected counters
   output logic [N-1:0]           save_pulse,       // Copy counter to hold
   output logic [N-1:0]           step_up_pulse,    // Step counter up
   output logic [N-1:0]           step_down_pulse,  // Step counter down
   output logic [N-1:0]           reload_hold_next, // Next TC reloads from hold
   output logic [N-1:0]           toggle_level,     // Toggle flop state
   output logic [N-1:0]           toggle_out,       // Toggle flop at counter output
   output logic                   master_reset_pulse, // Clear load, hold, mode regs
   output logic [MM_W-1:0]        master_mode,      // Master mode register
   output logic [1:0]             ptr_element,      // Pointer element field
   output logic [2:0]             ptr_group,        // Pointer group field
   output logic                   ptr_byte_first,   // Pointer byte-select bit
   output logic                   prefetch_wr_off,  // Write prefetch disabled
   output logic                   wide_bus_select,  // Sixteen-line bus mode
   output logic [WORD_W-1:0]      bus_data_out,     // Data bus buffer output
   output logic                   freq_output_pin,  // Frequency output level
   output logic                   freq_output_oe    // Frequency output drive enable
);
   // ---------------------------------------------
   // Decoding helpers
   // ---------------------------------------------
   function automatic tdc_cmd_t decode(input logic [7:0] b);
      logic [2:0] n;
      n = b[2:0];
      decode = C_NOP;
      unique case (b[7:5])
         OP_POINTER:
            if (n != GROUP_BAD_LO && n != GROUP_BAD_HI)
               decode = C_POINTER;
         OP_ARM:         decode = C_ARM;
         OP_LOAD:        decode = C_LOAD;
         OP_LOAD_ARM:    decode = C_LOAD_ARM;
         OP_DISARM_SAVE: decode = C_DIS_SAVE;
         OP_SAVE:        decode = C_SAVE;
         OP_DISARM:      decode = C_DISARM;
         OP_SPECIAL:
            unique case (b[4:3])
               SUB_TOG_SET:
                  if (n == N_PTR_SEQ)      decode = C_POINTER_ADVANCE_INHIBIT_SET;
                  else if (n == N_FREQ_OUTPUT_PIN)    decode = C_FREQ_OUT_GATE_OFF_SET;
                  else if (n == N_BUS)     decode = C_WIDE_BUS_SELECT_SET;
                  else if (n <= N_LAST)    decode = C_TOG_SET;
               SUB_TOG_CLR:
                  if (n == N_PTR_SEQ)      decode = C_POINTER_ADVANCE_INHIBIT_CLR;
                  else if (n == N_FREQ_OUTPUT_PIN)    decode = C_FREQ_OUT_GATE_OFF_CLR;
                  else if (n == N_BUS)     decode = C_WIDE_BUS_SELECT_CLR;
                  else if (n <= N_LAST)    decode = C_TOG_CLR;
               SUB_STEP:
                  if (n >= N_FIRST && n <= N_LAST) decode = C_STEP;
               SUB_MISC:
                  if (n == N_PF_ON)        decode = C_PF_ON;
                  else if (n == N_PF_OFF)  decode = C_PF_OFF;
                  else if (n == N_MRESET)  decode = C_MRESET;
            endcase
      endcase
   endfunction : decode

   function automatic logic [N-1:0] num_onehot(input logic [2:0] n);
      num_onehot = '0;
      if (n >= N_FIRST && n <= N_LAST)
         num_onehot[n - N_FIRST] = 1'b1;
   endfunction : num_onehot

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef struct packed {
      logic [N-1:0]      load_p;
      logic [N-1:0]      save_p;
      logic [N-1:0]      up_p;
      logic [N-1:0]      dn_p;
      logic [N-1:0]      rhold_p;
      logic [N-1:0]      toggle;
      logic              mreset_p;
      logic [MM_W-1:0]   mm;
      logic [1:0]        elem;
      logic [2:0]        group;
      logic              byte_first;
      logic              pf_off;
      logic [WORD_W-1:0] bus;
      logic              fpin;
   } tdc_state_t;

   tdc_state_t st_reg;
   tdc_state_t st_next;
   tdc_cmd_t   cmd;
   logic [N-1:0] sel;
   logic [N-1:0] num;
   logic [N-1:0] arm_cmd;
   logic [N-1:0] disarm_cmd;
   logic [N-1:0] leave_tc;
   logic         mclr;

   always_comb
   begin
      cmd        = cmd_valid ? decode(cmd_byte) : C_NOP;
      sel        = cmd_byte[N-1:0];
      num        = num_onehot(cmd_byte[2:0]);
      mclr       = (cmd == C_MRESET);
      arm_cmd    = (cmd == C_ARM || cmd == C_LOAD_ARM) ? sel : '0;
      disarm_cmd = (cmd == C_DISARM || cmd == C_DIS_SAVE) ? sel : '0;
      leave_tc   = source_edge
                 | ((cmd == C_LOAD || cmd == C_LOAD_ARM) ? sel : '0)
                 | ((cmd == C_STEP) ? num : '0);
   end

   // ---------------------------------------------
   // Per-counter arm control
   // ---------------------------------------------
   for (genvar i = 0; i < N; i++)
   begin : g_slice
      tdc_arm_slice u_slice (
         .clock      (clock),
         .reset      (reset),
         .arm_cmd    (arm_cmd[i]),
         .disarm_cmd (disarm_cmd[i]),
         .leave_tc   (leave_tc[i]),
         .at_tc      (terminal_count[i]),
         .tc_disarm  (tc_disarm[i]),
         .master_clr (mclr),
         .armed      (counter_armed[i])
      );
   end

   // ---------------------------------------------
   // Command execution and bus buffer
   // ---------------------------------------------
   always_comb
   begin
      st_next          = st_reg;
      st_next.load_p   = '0;
      st_next.save_p   = '0;
      st_next.up_p     = '0;
      st_next.dn_p     = '0;
      st_next.rhold_p  = '0;
      st_next.mreset_p = 1'b0;
      st_next.toggle   = st_reg.toggle ^ tc_toggle;
      if (mm_write)
         st_next.mm = mm_write_data;
      if (host_access)
      begin
         if (st_reg.mm[MM_WIDE_BIT])
            st_next.bus = internal_word;
         else if (st_reg.byte_first)
            st_next.bus = {{BYTE_W{1'b0}}, internal_word[BYTE_W-1:0]};
         else
            st_next.bus = {{BYTE_W{1'b0}}, internal_word[WORD_W-1:BYTE_W]};
         if (!st_reg.mm[MM_WIDE_BIT])
            st_next.byte_first = !st_reg.byte_first;
         if (!st_reg.mm[MM_PTR_INH_BIT] && (st_reg.mm[MM_WIDE_BIT] || !st_reg.byte_first))
            st_next.elem = st_reg.elem + 2'h1;
      end
      unique case (cmd)
         C_NOP: ;
         C_POINTER:
         begin
            st_next.elem       = cmd_byte[4:3];
            st_next.group      = cmd_byte[2:0];
            st_next.byte_first = 1'b1;
         end
         C_ARM:
            st_next.rhold_p = sel;
         C_LOAD:
            st_next.load_p = sel;
         C_LOAD_ARM:
         begin
            st_next.load_p  = sel;
            st_next.rhold_p = sel;
         end
         C_DIS_SAVE, C_SAVE:
            st_next.save_p = sel;
         C_DISARM: ;
         C_TOG_SET:
            st_next.toggle = st_reg.toggle | num;
         C_TOG_CLR:
            st_next.toggle = st_reg.toggle & ~num;
         C_STEP:
         begin
            st_next.up_p = num & count_up_select;
            st_next.dn_p = num & ~count_up_select;
         end
         C_POINTER_ADVANCE_INHIBIT_SET: st_next.mm[MM_PTR_INH_BIT]  = 1'b1;
         C_POINTER_ADVANCE_INHIBIT_CLR: st_next.mm[MM_PTR_INH_BIT]  = 1'b0;
         C_WIDE_BUS_SELECT_SET: st_next.mm[MM_WIDE_BIT]     = 1'b1;
         C_WIDE_BUS_SELECT_CLR: st_next.mm[MM_WIDE_BIT]     = 1'b0;
         C_FREQ_OUT_GATE_OFF_SET: st_next.mm[MM_FREQ_OUTPUT_PIN_OFF_BIT] = 1'b1;
         C_FREQ_OUT_GATE_OFF_CLR: st_next.mm[MM_FREQ_OUTPUT_PIN_OFF_BIT] = 1'b0;
         C_PF_ON:    st_next.pf_off = 1'b0;
         C_PF_OFF:   st_next.pf_off = 1'b1;
         C_MRESET:
         begin
            st_next.mm       = MASTER_MODE_RST;
            st_next.pf_off   = 1'b0;
            st_next.mreset_p = 1'b1;
         end
      endcase
      // Gate change reaches the pin in the same cycle as the mode bit
      st_next.fpin = st_next.mm[MM_FREQ_OUTPUT_PIN_OFF_BIT] ? 1'b0 : freq_divided;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         st_reg    <= '0;
         st_reg.mm <= MASTER_MODE_RST;
      end
      else
         st_reg <= st_next;
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign load_pulse         = st_reg.load_p;
   assign save_pulse         = st_reg.save_p;
   assign step_up_pulse      = st_reg.up_p;
   assign step_down_pulse    = st_reg.dn_p;
   assign reload_hold_next   = st_reg.rhold_p;
   assign toggle_level       = st_reg.toggle;
   assign master_reset_pulse = st_reg.mreset_p;
   assign master_mode        = st_reg.mm;
   assign ptr_element        = st_reg.elem;
   assign ptr_group          = st_reg.group;
   assign ptr_byte_first     = st_reg.byte_first;
   assign prefetch_wr_off    = st_reg.pf_off;
   assign wide_bus_select    = st_reg.mm[MM_WIDE_BIT];
   assign bus_data_out       = st_reg.bus;
   assign freq_output_pin    = st_reg.fpin;
   assign freq_output_oe     = 1'b1;
   for (genvar i = 0; i < N; i++)
   begin : g_tog
      assign toggle_out[i] = st_reg.toggle[i]
                           && (output_control_field[3*i +: 3] == OCF_TOGGLE);
   end

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_la_arm;
      cmd_valid && cmd_byte == 8'h61 |=> counter_armed[0] && load_pulse[0];
   endproperty
   a_la_arm: assert property (p_la_arm) else $error("load-and-arm failed");

   property p_la_rearm;
      cmd_valid && cmd_byte == 8'h61 && terminal_count[0] |=> counter_armed[0];
   endproperty
   a_la_rearm: assert property (p_la_rearm) else $error("no rearm at tc");

   property p_la_hold;
      cmd_valid && cmd_byte == 8'h62 |=> reload_hold_next == 5'h02;
   endproperty
   a_la_hold: assert property (p_la_hold) else $error("no hold reload");

   property p_disarm;
      cmd_valid && cmd_byte == 8'hC1 && !terminal_count[0]
         |=> !counter_armed[0] ##1 !counter_armed[0] || $past(cmd_valid);
   endproperty
   a_disarm: assert property (p_disarm) else $error("disarm ignored");

   property p_disarm_tc;
      cmd_valid && cmd_byte == 8'hC1 && terminal_count[0] && !source_edge[0]
         && counter_armed[0] |=> counter_armed[0];
   endproperty
   a_disarm_tc: assert property (p_disarm_tc) else $error("disarm at tc early");

   property p_save;
      cmd_valid && cmd_byte == 8'hBF && !tc_disarm[0]
         |=> save_pulse == 5'h1F && counter_armed[0] == $past(counter_armed[0]);
   endproperty
   a_save: assert property (p_save) else $error("save wrong");

   property p_dsave;
      cmd_valid && cmd_byte == 8'h81 && !terminal_count[0]
         |=> save_pulse[0] && !counter_armed[0];
   endproperty
   a_dsave: assert property (p_dsave) else $error("disarm-and-save wrong");

   property p_tog;
      cmd_valid && cmd_byte == 8'hE9 && !tc_toggle[0] |=> toggle_level[0]
         ##0 (toggle_out[0] == (output_control_field[2:0] == OCF_TOGGLE));
   endproperty
   a_tog: assert property (p_tog) else $error("toggle set wrong");

   property p_step;
      cmd_valid && cmd_byte == 8'hF2 && !count_up_select[1]
         |=> step_down_pulse == 5'h02 && step_up_pulse == 5'h00;
   endproperty
   a_step: assert property (p_step) else $error("step wrong");

   property p_ptr;
      cmd_valid && cmd_byte == 8'h0D && !host_access
         |=> ptr_element == 2'h1 && ptr_group == 3'h5 && ptr_byte_first;
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer load wrong");

   property p_pointer_advance_inhibit;
      cmd_valid && cmd_byte == 8'hE8 && !mm_write
         |=> master_mode[14] && master_mode[13:0] == $past(master_mode[13:0]);
   endproperty
   a_pointer_advance_inhibit: assert property (p_pointer_advance_inhibit) else $error("inhibit set wrong");

   property p_freq_output_pin;
      master_mode[MM_FREQ_OUTPUT_PIN_OFF_BIT] && $past(master_mode[MM_FREQ_OUTPUT_PIN_OFF_BIT])
         |-> !freq_output_pin && freq_output_oe;
   endproperty
   a_freq_output_pin: assert property (p_freq_output_pin) else $error("pin not held low");

   property p_mreset;
      cmd_valid && cmd_byte == 8'hFF
         |=> counter_armed == 5'h00 && master_mode == 16'h0000 && master_reset_pulse;
   endproperty
   a_mreset: assert property (p_mreset) else $error("master reset wrong");

   property p_nop;
      cmd_valid && cmd_byte == 8'hF0 && !mm_write && !host_access
         |=> $stable(master_mode) && $stable(ptr_group) && $stable(ptr_element);
   endproperty
   a_nop: assert property (p_nop) else $error("unused code acted");

   c_la:   cover property (cmd_valid && cmd_byte == 8'h7F ##1 counter_armed == 5'h1F);
   c_pend: cover property (cmd_valid && cmd_byte == 8'hC1 && terminal_count[0]);
   c_narw: cover property (host_access && !wide_bus_select ##1 host_access);
endmodule : tdc_decoder

// ---- inc/tdc_pkg.sv ----
// Constants and types for the timer command decoder
package tdc_pkg;
   localparam int          NUM_CNT         = 5;
   localparam int          MM_W            = 16;
   localparam int          WORD_W          = 16;
   localparam int          BYTE_W          = 8;
   // ---------------------------------------------
   // Command byte fields
   // ---------------------------------------------
   localparam logic [2:0]  OP_POINTER      = 3'h0;
   localparam logic [2:0]  OP_ARM          = 3'h1;
   localparam logic [2:0]  OP_LOAD         = 3'h2;
   localparam logic [2:0]  OP_LOAD_ARM     = 3'h3;
   localparam logic [2:0]  OP_DISARM_SAVE  = 3'h4;
   localparam logic [2:0]  OP_SAVE         = 3'h5;
   localparam logic [2:0]  OP_DISARM       = 3'h6;
   localparam logic [2:0]  OP_SPECIAL      = 3'h7;
   localparam logic [1:0]  SUB_TOG_CLR     = 2'h0;
   localparam logic [1:0]  SUB_TOG_SET     = 2'h1;
   localparam logic [1:0]  SUB_STEP        = 2'h2;
   localparam logic [1:0]  SUB_MISC        = 2'h3;
   localparam logic [2:0]  N_PTR_SEQ       = 3'h0;
   localparam logic [2:0]  N_FREQ_OUTPUT_PIN          = 3'h6;
   localparam logic [2:0]  N_BUS           = 3'h7;
   localparam logic [2:0]  N_PF_ON         = 3'h0;
   localparam logic [2:0]  N_PF_OFF        = 3'h1;
   localparam logic [2:0]  N_MRESET        = 3'h7;
   localparam logic [2:0]  N_FIRST         = 3'h1;
   localparam logic [2:0]  N_LAST          = 3'h5;
   localparam logic [2:0]  GROUP_BAD_LO    = 3'h0;
   localparam logic [2:0]  GROUP_BAD_HI    = 3'h6;
   // ---------------------------------------------
   // Master mode bits, reset values, output codes
   // ---------------------------------------------
   localparam int          MM_PTR_INH_BIT  = 14;
   localparam int          MM_WIDE_BIT     = 13;
   localparam int          MM_FREQ_OUTPUT_PIN_OFF_BIT = 12;
   localparam logic [15:0] MASTER_MODE_RST = 16'h0000;
   localparam logic [15:0] LOAD_HOLD_RST   = 16'h0000;
   localparam logic [15:0] CNT_MODE_RST    = 16'h0B00;
   localparam logic [2:0]  OCF_TOGGLE      = 3'h2;
   typedef enum logic [4:0] {
      C_NOP       = 5'h00,
      C_POINTER   = 5'h01,
      C_ARM       = 5'h02,
      C_LOAD      = 5'h03,
      C_LOAD_ARM  = 5'h04,
      C_DIS_SAVE  = 5'h05,
      C_SAVE      = 5'h06,
      C_DISARM    = 5'h07,
      C_TOG_SET   = 5'h08,
      C_TOG_CLR   = 5'h09,
      C_STEP      = 5'h0A,
      C_POINTER_ADVANCE_INHIBIT_SET  = 5'h0B,
      C_POINTER_ADVANCE_INHIBIT_CLR  = 5'h0C,
      C_WIDE_BUS_SELECT_SET  = 5'h0D,
      C_WIDE_BUS_SELECT_CLR  = 5'h0E,
      C_FREQ_OUT_GATE_OFF_SET  = 5'h0F,
      C_FREQ_OUT_GATE_OFF_CLR  = 5'h10,
      C_PF_ON     = 5'h11,
      C_PF_OFF    = 5'h12,
      C_MRESET    = 5'h13
   } tdc_cmd_t;
endpackage : tdc_pkg

// ---- rtl/tdc_arm_slice.sv ----
// Arm and pending-disarm state of one counter
`timescale 1ns/100ps
module tdc_arm_slice
   import tdc_pkg::*;
(
   input  wire logic clock,        // System clock
   input  wire logic reset,        // Synchronous reset
   input  wire logic arm_cmd,      // Arm or load-and-arm selects this counter
   input  wire logic disarm_cmd,   // Disarm or disarm-and-save selects this counter
   input  wire logic leave_tc,     // Source edge, load or step this cycle
   input  wire logic at_tc,        // Counter sits at terminal count
   input  wire logic tc_disarm,    // Datapath disarms on terminal count
   input  wire logic master_clr,   // Master reset command
   output logic      armed         // Counter may count
);
   typedef struct packed {
      logic armed;
      logic pending;
   } tdc_slice_t;

   tdc_slice_t s_reg;
   tdc_slice_t s_next;

   always_comb
   begin
      s_next = s_reg;
      if (master_clr)
         s_next = '0;
      else if (arm_cmd)
      begin
         s_next.armed   = 1'b1;
         s_next.pending = 1'b0;
      end
      else if (disarm_cmd)
      begin
         if (at_tc && !leave_tc)
            s_next.pending = 1'b1;
         else
            s_next.armed = 1'b0;
      end
      else if (s_reg.pending && leave_tc)
         s_next = '0;
      else if (tc_disarm)
         s_next.armed = 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign armed = s_reg.armed;
endmodule : tdc_arm_slice

// ---- tb/tdc_host.sv ----
// Host model that issues command bytes
`timescale 1ns/100ps
module tdc_host
   import tdc_pkg::*;
(
   input  wire logic       clock,     // System clock
   output logic            cmd_valid, // Command strobe
   output logic [7:0]      cmd_byte   // Command byte
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_byte  = 8'h00;
   end
   // Released byte lines show the inverse of the last value
   task automatic send(input logic [7:0] b);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_byte  <= b;
      @(posedge clock);
      cmd_valid <= 1'b0;
      cmd_byte  <= ~b;
   endtask : send
   task automatic start_up();
      send(8'hFF);
      send(8'h5F);
      send(8'h1B);
   endtask : start_up
endmodule : tdc_host

// ---- tb/tb.sv ----
// Self-checking bench for the timer command decoder
`timescale 1ns/100ps
module tb;
   import tdc_pkg::*;
   logic        clock, reset, cmd_valid, host_access, freq_divided, pb, pf, wide, fpin, foe;
   logic [7:0]  cmd_byte;
   logic [4:0]  tcnt, sedge, cu, armed, ld, sv, su, sd, tl, to, arm_e, s, rh, tdis;
   logic        mrp;
   logic [14:0] ocf;
   logic [15:0] iw, mm, mm_e, bdo;
   logic [1:0]  pe;
   logic [2:0]  pg;
   logic [7:0]  mmc [6] = '{8'hE8, 8'hE0, 8'hEF, 8'hE7, 8'hEE, 8'hE6};
   int          mmb [6] = '{14, 14, 13, 13, 12, 12};
   int          n_errors, num_checks, k, n, op;
   tdc_host host_i (.clock(clock), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));
   tdc_decoder tdc_decoder_i (
      .clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .terminal_count(tcnt), .source_edge(sedge), .tc_disarm(tdis), .tc_toggle(5'h00),
      .count_up_select(cu), .output_control_field(ocf), .mm_write(1'b0),
      .mm_write_data(16'h0000), .host_access(host_access), .internal_word(iw),
      .freq_divided(freq_divided), .counter_armed(armed), .load_pulse(ld), .save_pulse(sv),
      .step_up_pulse(su), .step_down_pulse(sd), .reload_hold_next(rh), .toggle_level(tl),
      .toggle_out(to), .master_reset_pulse(mrp), .master_mode(mm), .ptr_element(pe),
      .ptr_group(pg), .ptr_byte_first(pb), .prefetch_wr_off(pf), .wide_bus_select(wide),
      .bus_data_out(bdo), .freq_output_pin(fpin), .freq_output_oe(foe));
   // ------------------------------
   // Helpers
   // ------------------------------
   function automatic logic [4:0] arm_f(input int o, input logic [4:0] m, input logic [4:0] a);
      return (o == 3) ? (a | m) : ((o == 4 || o == 6) ? (a & ~m) : a);
   endfunction : arm_f
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk
   task automatic cmd(input logic [7:0] b);
      host_i.send(b);
      #1;
   endtask : cmd
   task automatic access();
      @(posedge clock);
      host_access <= 1'b1;
      iw          <= 16'($urandom);
      @(posedge clock);
      host_access <= 1'b0;
      #1;
   endtask : access
   task automatic edge0();
      @(posedge clock) sedge <= 5'h01;
      @(posedge clock) sedge <= 5'h00;
      #1;
   endtask : edge0
   task automatic results();
      if (n_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      n_errors++;
      results();
   end
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial
   begin
      reset = 1'b1; host_access = 1'b0; freq_divided = 1'b0;
      tcnt = '0; sedge = '0; cu = '0; ocf = '0; iw = '0; mm_e = '0;
      tdis = '0;
      n_errors = 0; num_checks = 0;
      k = $urandom(32'h0AA94901);
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      host_i.start_up();
      #1;
      chk("armed", 16'h0000, armed);
      chk("pointer", 16'h003B, {pb, pe, pg});
      cmd(8'h7F);
      chk("armed", 16'h001F, armed);
      chk("reload_hold", 16'h001F, rh);
      cmd(8'h1E);
      chk("pointer", 16'h003B, {pb, pe, pg});
      cmd(8'hF0);
      cmd(8'h06);
      chk("idle", 16'h001F, {mm[15:5], armed});
      arm_e = 5'h1F;
      for (k = 0; k < 24; k++)
      begin
         op = (k < 4) ? 3 + k : 3 + $urandom % 4;
         s  = 5'($urandom);
         cmd({op[2:0], s});
         chk("load", {11'h0, (op == 3) ? s : 5'h00}, ld);
         chk("save", {11'h0, (op == 4 || op == 5) ? s : 5'h00}, sv);
         arm_e = arm_f(op, s, arm_e);
         chk("armed", {11'h0, arm_e}, armed);
      end
      cmd(8'h61);
      @(posedge clock) tcnt <= 5'h01;
      cmd(8'hC1);
      chk("armed0", 16'h0001, armed[0]);
      edge0();
      chk("armed0", 16'h0000, armed[0]);
      cmd(8'h61);
      cmd(8'hC1);
      cmd(8'h61);
      edge0();
      chk("armed0", 16'h0001, armed[0]);
      @(posedge clock) tdis <= 5'h01;
      @(posedge clock) tdis <= 5'h00;
      #1;
      chk("armed0", 16'h0000, armed[0]);
      cmd(8'h61);
      chk("armed0", 16'h0001, armed[0]);
      @(posedge clock) tcnt <= 5'h00;
      cmd(8'hC1);
      chk("armed0", 16'h0000, armed[0]);
      cmd(8'h62);
      chk("reload_hold", 16'h0002, rh);
      cmd(8'h81);
      chk("save", 16'h0001, sv);
      cmd(8'hBF);
      chk("save", 16'h001F, sv);
      for (n = 1; n <= 5; n++)
      begin
         @(posedge clock);
         ocf <= 15'($urandom);
         cu  <= 5'($urandom);
         cmd(8'hE8 | n[7:0]);
         chk("toggle", 16'h0001, tl[n-1]);
         chk("tog_out", ocf[3*n-3 +: 3] == OCF_TOGGLE, to[n-1]);
         cmd(8'hF0 | n[7:0]);
         chk("step_up", cu & (5'h01 << (n - 1)), su);
         chk("step_dn", ~cu & (5'h01 << (n - 1)), sd);
         cmd(8'hE0 | n[7:0]);
         chk("tog_out", 16'h0000, {tl[n-1], to[n-1]});
      end
      for (k = 0; k < 16; k++)
      begin
         n = (k < 6) ? k : $urandom % 6;
         @(posedge clock) freq_divided <= 1'($urandom);
         cmd(mmc[n]);
         mm_e[mmb[n]] = ~n[0];
         chk("master_mode", mm_e, mm);
         chk("wide", mm_e[13], wide);
         @(posedge clock);
         #1;
         chk("freq_pin", freq_divided & ~mm_e[12], fpin);
         chk("freq_oe", 16'h0001, foe);
      end
      cmd(8'hE8);
      cmd(8'hEF);
      for (k = 0; k < 3; k++)
      begin
         access();
         chk("bus_data", iw, bdo);
         chk("element", 16'h0003, pe);
      end
      cmd(8'hE0);
      access();
      chk("element", 16'h0000, pe);
      cmd(8'hE7);
      cmd(8'h1B);
      access();
      chk("low_byte", iw[7:0], bdo[7:0]);
      access();
      chk("high_byte", iw[15:8], bdo[7:0]);
      chk("element", 16'h0000, pe);
      cmd(8'h0D);
      chk("pointer", 16'h002D, {pb, pe, pg});
      cmd(8'hF9);
      chk("prefetch", 16'h0001, pf);
      cmd(8'hF0);
      chk("prefetch", 16'h0001, pf);
      cmd(8'hF8);
      chk("prefetch", 16'h0000, pf);
      cmd(8'hF9);
      cmd(8'hFF);
      chk("reset", 16'h0000, {pf, armed});
      chk("master_mode", 16'h0000, mm);
      chk("mreset_pulse", 16'h0001, mrp);
      results();
   end
endmodule : tb
